// ---- verilog/pirq_flags.sv ----
// Overview of operation
// - Flags set regardless of any enable bit.
// - Flag reads one while pending, else zero.
// - Every reset clears all three flag registers.
// - Unimplemented bit positions always read zero.
// - Bank b bit 7: oscillator failure flag.
// - Bank b bits 6, 5: comparators two, one.
// - Bank b bit 4: nonvolatile write done.
// - Bank b bit 3: serial port a collision.
// - Bank b bit 2: LCD driver flag.
// - Bank b bit 0: capture/compare two flag.
// - Bank c bits 6-4: capture/compare five-three.
// - Bank c bit 3: timer six period match.
// - Bank c bit 1: timer four period match.
// - Bank d bits 5, 4: USART b rx, tx.
// - Bank d bit 1: serial port b collision.
// - Request needs own enable and peripheral enable.
module pirq_flags
   import pirq_pkg::*;
(
   // Clock and reset.
   input  wire logic          clk_i,
   input  wire logic          sys_rst_i,
   // Register port.
   input  wire pirq_bus_req_t bus_req_i,
   output logic [7:0]         rd_data_o,
   // Peripheral events.
   input  wire pirq_evt_t     evt_i,
   // Gated interrupt request.
   output logic               periph_irq_req_o
);

   typedef struct packed {
      logic [7:0] rd_data;
      logic       periph_en;
   } pirq_state_t;

   pirq_state_t state_reg;
   pirq_state_t state_next;

   pirq_bank_t  set_vec;
   pirq_bank_t  flags;
   pirq_bank_t  enables;
   logic [2:0]  flag_wr;
   logic [2:0]  en_wr;
   logic        core_wr;

   // True for a request aimed at a given offset.
   function automatic logic addr_hit(input pirq_bus_req_t req, input logic [3:0] ofs);
      addr_hit = (req.addr == ofs);
   endfunction

   // Maps each peripheral event onto its bank and bit position.
   function automatic pirq_bank_t events_to_set(input pirq_evt_t e);
      pirq_bank_t s;
      s = '0;
      s[0][PIRQ_BIT_OSC_FAIL]      = e.osc_fail;
      s[0][PIRQ_BIT_CMP_TWO]       = e.comparator_two;
      s[0][PIRQ_BIT_CMP_ONE]       = e.comparator_one;
      s[0][PIRQ_BIT_NV_DONE]       = e.nv_write_done;
      s[0][PIRQ_BIT_SER_A_COLL]    = e.serial_a_collision;
      s[0][PIRQ_BIT_LCD]           = e.lcd_driver;
      s[0][PIRQ_BIT_CAPCMP_TWO]    = e.capcmp_two;
      s[1][PIRQ_BIT_CAPCMP_FIVE]   = e.capcmp_five;
      s[1][PIRQ_BIT_CAPCMP_FOUR]   = e.capcmp_four;
      s[1][PIRQ_BIT_CAPCMP_THREE]  = e.capcmp_three;
      s[1][PIRQ_BIT_TIMER_SIX]     = e.timer_six_match;
      s[1][PIRQ_BIT_TIMER_FOUR]    = e.timer_four_match;
      s[2][PIRQ_BIT_USART_B_RX]    = e.usart_b_rx;
      s[2][PIRQ_BIT_USART_B_TX]    = e.usart_b_tx;
      s[2][PIRQ_BIT_SER_B_COLL]    = e.serial_b_collision;
      s[2][PIRQ_BIT_SER_B_EVT]     = e.serial_b_event;
      return s;
   endfunction

   // Events feed the flags directly; no enable is consulted here.
   assign set_vec = events_to_set(evt_i);

   // Write strobes per register.
   assign core_wr = bus_req_i.wr && addr_hit(bus_req_i, PIRQ_OFS_CORE);

   // Flag and enable registers share one stored-bit module.
   for (genvar g = 0; g < PIRQ_NBANK; g++) begin : g_bank
      assign flag_wr[g] = bus_req_i.wr && addr_hit(bus_req_i, PIRQ_FLAG_OFS[g]);
      assign en_wr[g]   = bus_req_i.wr && addr_hit(bus_req_i, PIRQ_EN_OFS[g]);

      // Set wins over a written zero inside the register.
      pirq_flag_reg #(
         .WIDTH (PIRQ_DW),
         .IMPL  (PIRQ_IMPL_MASK[g]),
         .RST   (PIRQ_RST_FLAGS)
      ) u_flag (
         .clk_i     (clk_i),
         .sys_rst_i (sys_rst_i),
         .wr_en_i   (flag_wr[g]),
         .wr_data_i (bus_req_i.wr_data),
         .set_i     (set_vec[g]),
         .value_o   (flags[g])
      );

      pirq_flag_reg #(
         .WIDTH (PIRQ_DW),
         .IMPL  (PIRQ_IMPL_MASK[g]),
         .RST   (PIRQ_RST_EN)
      ) u_enable (
         .clk_i     (clk_i),
         .sys_rst_i (sys_rst_i),
         .wr_en_i   (en_wr[g]),
         .wr_data_i (bus_req_i.wr_data),
         .set_i     ('0),
         .value_o   (enables[g])
      );
   end

   // Request gating against the flag enables and the peripheral enable.
   pirq_req_gate u_gate (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .flags_i     (flags),
      .enables_i   (enables),
      .periph_en_i (state_reg.periph_en),
      .req_o       (periph_irq_req_o)
   );

   // Read data appears for exactly one cycle after the read strobe.
   always_comb begin
      state_next         = state_reg;
      state_next.rd_data = 8'h00;
      if (core_wr) begin
         state_next.periph_en = bus_req_i.wr_data[PIRQ_BIT_PERIPH_EN];
      end
      if (bus_req_i.rd) begin
         case (bus_req_i.addr)
            PIRQ_OFS_FLAGS_B: state_next.rd_data = flags[0];
            PIRQ_OFS_FLAGS_C: state_next.rd_data = flags[1];
            PIRQ_OFS_FLAGS_D: state_next.rd_data = flags[2];
            PIRQ_OFS_EN_B:    state_next.rd_data = enables[0];
            PIRQ_OFS_EN_C:    state_next.rd_data = enables[1];
            PIRQ_OFS_EN_D:    state_next.rd_data = enables[2];
            PIRQ_OFS_CORE: begin
               state_next.rd_data                     = 8'h00;
               state_next.rd_data[PIRQ_BIT_PERIPH_EN] = state_reg.periph_en;
            end
            default:          state_next.rd_data = 8'h00;
         endcase
      end
   end

   // Every reset clears the local state as well as the banks.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_reg.rd_data   <= 8'h00;
         state_reg.periph_en <= PIRQ_RST_PEN;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rd_data_o = state_reg.rd_data;

   // Checks on the flag banks and the request gate.

   a_osc_fail_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      evt_i.osc_fail |=> flags[0][PIRQ_BIT_OSC_FAIL])
      else $error("Oscillator failure event did not set its flag.");

   a_comparator_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (evt_i.comparator_two || evt_i.comparator_one) |=>
      (flags[0][PIRQ_BIT_CMP_TWO] == $past(evt_i.comparator_two) ||
       flags[0][PIRQ_BIT_CMP_TWO]) &&
      (flags[0][PIRQ_BIT_CMP_ONE] || !$past(evt_i.comparator_one)))
      else $error("Comparator event did not set its flag.");

   a_nv_done_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      evt_i.nv_write_done |=> flags[0][PIRQ_BIT_NV_DONE])
      else $error("Write completion event did not set its flag.");

   a_serial_a_coll: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      evt_i.serial_a_collision |=> flags[0][PIRQ_BIT_SER_A_COLL])
      else $error("Serial port a collision did not set its flag.");

   a_lcd_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      evt_i.lcd_driver |=> flags[0][PIRQ_BIT_LCD])
      else $error("LCD event did not set its flag.");

   a_capcmp_two_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      evt_i.capcmp_two |=> flags[0][PIRQ_BIT_CAPCMP_TWO])
      else $error("Capture compare two event did not set its flag.");

   a_capcmp_c_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (evt_i.capcmp_five || evt_i.capcmp_four || evt_i.capcmp_three) |=>
      (flags[1][PIRQ_BIT_CAPCMP_FIVE] || !$past(evt_i.capcmp_five)) &&
      (flags[1][PIRQ_BIT_CAPCMP_FOUR] || !$past(evt_i.capcmp_four)) &&
      (flags[1][PIRQ_BIT_CAPCMP_THREE] || !$past(evt_i.capcmp_three)))
      else $error("Capture compare event did not set its flag.");

   a_timer_six_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      evt_i.timer_six_match |=> flags[1][PIRQ_BIT_TIMER_SIX])
      else $error("Timer six match did not set its flag.");

   a_timer_four_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      evt_i.timer_four_match |=> flags[1][PIRQ_BIT_TIMER_FOUR])
      else $error("Timer four match did not set its flag.");

   a_usart_b_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      evt_i.usart_b_rx && !evt_i.usart_b_tx && !flags[2][PIRQ_BIT_USART_B_TX] &&
      !bus_req_i.wr |=> flags[2][PIRQ_BIT_USART_B_RX] && !flags[2][PIRQ_BIT_USART_B_TX])
      else $error("USART b receive event landed on the wrong bit.");

   a_serial_b_coll: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      evt_i.serial_b_collision |=> flags[2][PIRQ_BIT_SER_B_COLL])
      else $error("Serial port b collision did not set its flag.");

   a_serial_b_evt: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      evt_i.serial_b_event |=> flags[2][PIRQ_BIT_SER_B_EVT])
      else $error("Serial port b event did not set its flag.");

   a_unimpl_bits_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      bus_req_i.rd && bus_req_i.addr == PIRQ_OFS_FLAGS_C |=>
      (rd_data_o & ~PIRQ_MASK_C) == 8'h00)
      else $error("Unimplemented flag bit read as one.");

   a_reset_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $fell(sys_rst_i) |-> flags == '0 && !periph_irq_req_o && rd_data_o == 8'h00)
      else $error("Flags not clear after reset.");

   a_read_returns: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      bus_req_i.rd && bus_req_i.addr == PIRQ_OFS_FLAGS_D |=> rd_data_o == $past(flags[2]))
      else $error("Flag read did not return the pending state.");

   a_flag_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      flags[1][PIRQ_BIT_TIMER_SIX] && !flag_wr[1] |=> flags[1][PIRQ_BIT_TIMER_SIX])
      else $error("Flag dropped without a software write.");

   a_event_wins: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      flag_wr[0] && !bus_req_i.wr_data[PIRQ_BIT_LCD] && evt_i.lcd_driver
      |=> flags[0][PIRQ_BIT_LCD])
      else $error("Event lost against a clearing write.");

   a_write_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      flag_wr[0] && !bus_req_i.wr_data[PIRQ_BIT_LCD] && !evt_i.lcd_driver
      |=> !flags[0][PIRQ_BIT_LCD])
      else $error("Written zero did not clear the flag.");

   a_irq_gated: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      periph_irq_req_o |-> $past(state_reg.periph_en) && ($past(flags & enables) != '0))
      else $error("Request raised without both enables.");

   a_irq_raised: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      state_reg.periph_en && (flags & enables) != '0 |=> periph_irq_req_o)
      else $error("Enabled pending flag gave no request.");

   // Flag, read path, reset and request checks; the reset check runs without a disable on purpose.

   a_usart_b_tx_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      evt_i.usart_b_tx |=> flags[2][PIRQ_BIT_USART_B_TX])
      else $error("USART b transmit event did not set its flag.");

   a_unimpl_b_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      bus_req_i.rd && bus_req_i.addr == PIRQ_OFS_FLAGS_B |=>
      (rd_data_o & ~PIRQ_MASK_B) == 8'h00)
      else $error("Unimplemented bank b bit read as one.");

   a_unimpl_d_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      bus_req_i.rd && bus_req_i.addr == PIRQ_OFS_FLAGS_D |=>
      (rd_data_o & ~PIRQ_MASK_D) == 8'h00)
      else $error("Unimplemented bank d bit read as one.");

   a_read_b_returns: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      bus_req_i.rd && bus_req_i.addr == PIRQ_OFS_FLAGS_B |=> rd_data_o == $past(flags[0]))
      else $error("Bank b read did not return the pending state.");

   a_read_c_returns: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      bus_req_i.rd && bus_req_i.addr == PIRQ_OFS_FLAGS_C |=> rd_data_o == $past(flags[1]))
      else $error("Bank c read did not return the pending state.");

   a_rd_idle_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !bus_req_i.rd |=> rd_data_o == 8'h00)
      else $error("Read data stood without a read strobe.");

   a_no_spurious_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !flags[1][PIRQ_BIT_TIMER_FOUR] && !evt_i.timer_four_match && !flag_wr[1] |=>
      !flags[1][PIRQ_BIT_TIMER_FOUR])
      else $error("Flag rose with no event and no write.");

   a_set_ignores_en: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      evt_i.lcd_driver && !enables[0][PIRQ_BIT_LCD] && !state_reg.periph_en |=>
      flags[0][PIRQ_BIT_LCD])
      else $error("Disabled source failed to set its flag.");

   a_osc_fail_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      flags[0][PIRQ_BIT_OSC_FAIL] && !flag_wr[0] |=> flags[0][PIRQ_BIT_OSC_FAIL])
      else $error("Oscillator failure flag dropped without a write.");

   a_reset_clears_all: assert property (@(posedge clk_i)
      sys_rst_i |=> flags == '0 && enables == '0 && !periph_irq_req_o && rd_data_o == 8'h00)
      else $error("Reset did not clear the register state.");

   a_core_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      core_wr |=> state_reg.periph_en == $past(bus_req_i.wr_data[PIRQ_BIT_PERIPH_EN]))
      else $error("Peripheral enable did not take the written value.");

   a_irq_needs_en: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !state_reg.periph_en |=> !periph_irq_req_o)
      else $error("Request raised with the peripheral enable off.");

   a_req_drops: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (flags & enables) == '0 |=> !periph_irq_req_o)
      else $error("Request stood with no enabled pending flag.");

   a_en_read_d: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      bus_req_i.rd && bus_req_i.addr == PIRQ_OFS_EN_D |=> rd_data_o == $past(enables[2]))
      else $error("Enable read did not return the stored value.");

endmodule

// ---- verilog/pirq_pkg.sv ----
package pirq_pkg;

   // Bus and data widths of the register port.
   localparam int unsigned PIRQ_DW    = 8;
   localparam int unsigned PIRQ_AW    = 4;
   localparam int unsigned PIRQ_NBANK = 3;

   // Register offsets on the plain register port.
   localparam logic [3:0] PIRQ_OFS_FLAGS_B = 4'h0;
   localparam logic [3:0] PIRQ_OFS_FLAGS_C = 4'h1;
   localparam logic [3:0] PIRQ_OFS_FLAGS_D = 4'h2;
   localparam logic [3:0] PIRQ_OFS_EN_B    = 4'h4;
   localparam logic [3:0] PIRQ_OFS_EN_C    = 4'h5;
   localparam logic [3:0] PIRQ_OFS_EN_D    = 4'h6;
   localparam logic [3:0] PIRQ_OFS_CORE    = 4'h7;

   // Implemented bit positions of each bank; the other positions read as zero.
   localparam logic [7:0] PIRQ_MASK_B = 8'hFD;
   localparam logic [7:0] PIRQ_MASK_C = 8'h7A;
   localparam logic [7:0] PIRQ_MASK_D = 8'h33;

   // Reset values.
   localparam logic [7:0] PIRQ_RST_FLAGS = 8'h00;
   localparam logic [7:0] PIRQ_RST_EN    = 8'h00;
   localparam logic       PIRQ_RST_PEN   = 1'h0;

   // Field positions in bank b.
   localparam int unsigned PIRQ_BIT_OSC_FAIL   = 7;
   localparam int unsigned PIRQ_BIT_CMP_TWO    = 6;
   localparam int unsigned PIRQ_BIT_CMP_ONE    = 5;
   localparam int unsigned PIRQ_BIT_NV_DONE    = 4;
   localparam int unsigned PIRQ_BIT_SER_A_COLL = 3;
   localparam int unsigned PIRQ_BIT_LCD        = 2;
   localparam int unsigned PIRQ_BIT_CAPCMP_TWO = 0;
   // Field positions in bank c.
   localparam int unsigned PIRQ_BIT_CAPCMP_FIVE  = 6;
   localparam int unsigned PIRQ_BIT_CAPCMP_FOUR  = 5;
   localparam int unsigned PIRQ_BIT_CAPCMP_THREE = 4;
   localparam int unsigned PIRQ_BIT_TIMER_SIX    = 3;
   localparam int unsigned PIRQ_BIT_TIMER_FOUR   = 1;
   // Field positions in bank d.
   localparam int unsigned PIRQ_BIT_USART_B_RX   = 5;
   localparam int unsigned PIRQ_BIT_USART_B_TX   = 4;
   localparam int unsigned PIRQ_BIT_SER_B_COLL   = 1;
   localparam int unsigned PIRQ_BIT_SER_B_EVT    = 0;
   // Peripheral enable position in the core control register.
   localparam int unsigned PIRQ_BIT_PERIPH_EN    = 6;

   typedef logic [7:0]           pirq_byte_t;
   typedef pirq_byte_t [2:0]     pirq_bank_t;

   // Bank index 0 is b, 1 is c, 2 is d.
   localparam pirq_bank_t PIRQ_IMPL_MASK = {PIRQ_MASK_D, PIRQ_MASK_C, PIRQ_MASK_B};
   localparam logic [3:0] PIRQ_FLAG_OFS [0:2] = '{PIRQ_OFS_FLAGS_B, PIRQ_OFS_FLAGS_C,
                                                  PIRQ_OFS_FLAGS_D};
   localparam logic [3:0] PIRQ_EN_OFS [0:2]   = '{PIRQ_OFS_EN_B, PIRQ_OFS_EN_C,
                                                  PIRQ_OFS_EN_D};

   // One request of the register port.
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wr_data;
      logic       wr;
      logic       rd;
   } pirq_bus_req_t;

   // One-cycle event strobes from the peripherals.
   typedef struct packed {
      logic osc_fail;
      logic comparator_two;
      logic comparator_one;
      logic nv_write_done;
      logic serial_a_collision;
      logic lcd_driver;
      logic capcmp_two;
      logic capcmp_five;
      logic capcmp_four;
      logic capcmp_three;
      logic timer_six_match;
      logic timer_four_match;
      logic usart_b_rx;
      logic usart_b_tx;
      logic serial_b_collision;
      logic serial_b_event;
   } pirq_evt_t;

endpackage

// ---- verilog/pirq_flag_reg.sv ----
module pirq_flag_reg
   import pirq_pkg::*;
#(
   parameter int unsigned  WIDTH = 8,
   parameter logic [7:0]   IMPL  = 8'hFF,
   parameter logic [7:0]   RST   = 8'h00
) (
   // Clock and reset.
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   // Software write.
   input  wire logic             wr_en_i,
   input  wire logic [WIDTH-1:0] wr_data_i,
   // Hardware set.
   input  wire logic [WIDTH-1:0] set_i,
   // Stored value.
   output logic      [WIDTH-1:0] value_o
);

   typedef struct packed {
      logic [WIDTH-1:0] value;
   } pirq_fr_state_t;

   pirq_fr_state_t state_reg;
   pirq_fr_state_t state_next;

   // The mask only covers an eight bit register.
   if (WIDTH != 8) begin : g_bad_width
      $error("pirq_flag_reg supports only WIDTH of 8");
   end

   // A write stores its data, a set in the same cycle overrides a written zero.
   always_comb begin
      state_next = state_reg;
      if (wr_en_i) begin
         state_next.value = wr_data_i;
      end
      state_next.value = (state_next.value | set_i) & IMPL;
   end

   // Every reset source clears the register.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_reg.value <= RST & IMPL;
      end else begin
         state_reg <= state_next;
      end
   end

   assign value_o = state_reg.value;

endmodule

// ---- verilog/pirq_req_gate.sv ----
module pirq_req_gate
   import pirq_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   // Pending flags and their enables.
   input  wire pirq_bank_t flags_i,
   input  wire pirq_bank_t enables_i,
   input  wire logic       periph_en_i,
   // Registered request.
   output logic            req_o
);

   typedef struct packed {
      logic req;
   } pirq_rg_state_t;

   pirq_rg_state_t state_reg;
   pirq_rg_state_t state_next;

   // A pending flag counts only with its own enable and the peripheral enable.
   always_comb begin
      state_next     = state_reg;
      state_next.req = periph_en_i && ((flags_i & enables_i) != '0);
   end

   // Registering the request keeps the output glitch free.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_reg.req <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign req_o = state_reg.req;

endmodule

// ---- bench/pirq_periph_model.sv ----
module pirq_periph_model
   import pirq_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   // Command from the bench.
   input  wire logic       fire_i,
   input  wire logic [3:0] idx_i,
   input  wire logic [3:0] dly_i,
   // Event strobes and status.
   output pirq_evt_t       evt_o,
   output logic            busy_o
);
   timeunit 1ns;
   timeprecision 1ns;

   logic       armed_reg;
   logic [3:0] cnt_reg;
   logic [3:0] idx_reg;

   // A peripheral raises its condition either at once or some cycles late, as commanded.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         armed_reg <= 1'b0;
         cnt_reg   <= 4'h0;
         idx_reg   <= 4'h0;
      end else if (fire_i) begin
         armed_reg <= 1'b1;
         cnt_reg   <= dly_i;
         idx_reg   <= idx_i;
      end else if (armed_reg) begin
         if (cnt_reg == 4'h0) begin
            armed_reg <= 1'b0;
         end else begin
            cnt_reg <= cnt_reg - 4'h1;
         end
      end
   end

   // The strobe lasts one cycle only, so the flag has to hold the condition by itself.
   assign evt_o  = (armed_reg && cnt_reg == 4'h0) ? pirq_evt_t'(16'h0001 << idx_reg) : '0;
   assign busy_o = armed_reg;
endmodule

// ---- bench/pirq_flags_tb_top.sv ----
module pirq_flags_tb_top
   import pirq_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;

   // Bank and bit of each event strobe, indexed by its position in the event struct.
   localparam int EV_BANK [16] = '{2, 2, 2, 2, 1, 1, 1, 1, 1, 0, 0, 0, 0, 0, 0, 0};
   localparam int EV_BIT  [16] = '{0, 1, 4, 5, 1, 3, 4, 5, 6, 0, 2, 3, 4, 5, 6, 7};

   logic          clk;
   logic          sys_rst;
   pirq_bus_req_t bus_req;
   logic [7:0]    rd_data;
   pirq_evt_t     evt;
   logic          irq_req;
   logic          fire;
   logic [3:0]    fire_idx;
   logic [3:0]    fire_dly;
   logic          busy;
   int            err_count;
   int            cmp_count;
   int            i;

   // Free-running system clock.
   always #5 clk = ~clk;

   pirq_flags pirq_flags_i (
      .clk_i            (clk),
      .sys_rst_i        (sys_rst),
      .bus_req_i        (bus_req),
      .rd_data_o        (rd_data),
      .evt_i            (evt),
      .periph_irq_req_o (irq_req)
   );

   pirq_periph_model pirq_periph_model_i (
      .clk_i     (clk),
      .sys_rst_i (sys_rst),
      .fire_i    (fire),
      .idx_i     (fire_idx),
      .dly_i     (fire_dly),
      .evt_o     (evt),
      .busy_o    (busy)
   );

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_req <= '{addr: a, wr_data: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus_req <= '0;
   endtask

   // Read data stand only in the cycle after the read strobe, so they are sampled there.
   task automatic bus_rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus_req <= '{addr: a, wr_data: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus_req <= '0;
      #1;
      check(rd_data, exp);
   endtask

   // Waits for the peripheral under a bound, so a stuck model cannot hang the run.
   task automatic raise(input int idx, input int dly);
      int n;
      n = 0;
      @(posedge clk);
      fire     <= 1'b1;
      fire_idx <= 4'(idx);
      fire_dly <= 4'(dly);
      @(posedge clk);
      fire <= 1'b0;
      #1;
      while (busy === 1'b1 && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask

   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Watchdog sized well above the few hundred cycles the sequence needs.
   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      $display("mismatch at %0t: run timed out", $time);
      test_done();
   end

   // Main sequence.
   initial begin
      clk       = 1'b0;
      sys_rst   = 1'b1;
      bus_req   = '0;
      fire      = 1'b0;
      fire_idx  = 4'h0;
      fire_dly  = 4'h0;
      err_count = 0;
      cmp_count = 0;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      // Every address, mapped or not, reads zero after reset.
      for (i = 0; i < 16; i++) begin
         bus_rd(4'(i), 8'h00);
      end
      // Only implemented positions take a one; the unmapped hole ignores writes.
      for (i = 0; i < 3; i++) begin
         bus_wr(PIRQ_FLAG_OFS[i], 8'hFF);
         bus_rd(PIRQ_FLAG_OFS[i], PIRQ_IMPL_MASK[i]);
         bus_wr(PIRQ_EN_OFS[i], 8'hFF);
         bus_rd(PIRQ_EN_OFS[i], PIRQ_IMPL_MASK[i]);
         bus_wr(PIRQ_FLAG_OFS[i], 8'h00);
         bus_rd(PIRQ_FLAG_OFS[i], 8'h00);
         bus_wr(PIRQ_EN_OFS[i], 8'h00);
      end
      bus_wr(4'h3, 8'hFF);
      bus_rd(4'h3, 8'h00);
      // Each source sets its own bit with every enable off; prompt and late sources alternate.
      for (i = 0; i < 16; i++) begin
         raise(i, (i % 2) * 3);
         bus_rd(PIRQ_FLAG_OFS[EV_BANK[i]], 8'(1 << EV_BIT[i]));
         bus_rd(PIRQ_FLAG_OFS[EV_BANK[i]], 8'(1 << EV_BIT[i]));
         bus_wr(PIRQ_FLAG_OFS[EV_BANK[i]], 8'h00);
         bus_rd(PIRQ_FLAG_OFS[EV_BANK[i]], 8'h00);
      end
      // A zero written in the very cycle of a new event must lose to the event.
      fork
         raise(10, 0);
         begin
            @(posedge clk);
            bus_wr(PIRQ_OFS_FLAGS_B, 8'h00);
         end
      join
      bus_rd(PIRQ_OFS_FLAGS_B, 8'h04);
      // The own enable alone does not raise the request; the peripheral enable is needed too.
      bus_wr(PIRQ_OFS_EN_B, 8'h04);
      repeat (2) @(posedge clk);
      #1;
      check({7'h00, irq_req}, 8'h00);
      bus_wr(PIRQ_OFS_CORE, 8'hFF);
      bus_rd(PIRQ_OFS_CORE, 8'h40);
      check({7'h00, irq_req}, 8'h01);
      bus_wr(PIRQ_OFS_FLAGS_B, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      check({7'h00, irq_req}, 8'h00);
      // A reset in mid-run drops pending flags and a standing request.
      bus_wr(PIRQ_OFS_EN_B, 8'h80);
      raise(15, 0);
      raise(3, 2);
      bus_rd(PIRQ_OFS_FLAGS_B, 8'h80);
      check({7'h00, irq_req}, 8'h01);
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      for (i = 0; i < 3; i++) begin
         bus_rd(PIRQ_FLAG_OFS[i], 8'h00);
      end
      check({7'h00, irq_req}, 8'h00);
      // A stale flag is cleared before its enables go on, so no request follows.
      raise(15, 0);
      bus_wr(PIRQ_OFS_FLAGS_B, 8'h00);
      bus_wr(PIRQ_OFS_EN_B, 8'h80);
      bus_wr(PIRQ_OFS_CORE, 8'h40);
      repeat (2) @(posedge clk);
      #1;
      check({7'h00, irq_req}, 8'h00);
      test_done();
   end
endmodule
